// ==== wqct_pkg.sv ====
/*
 * Constants, field layout and types of the work queue configuration table.
 * Assumes a single clock domain and a byte address space for the table.
 */
package wqct_pkg;
   // Table geometry
   localparam int NUM_WQ = 8;
   localparam int IDX_W = 3;
   localparam int ADDR_W = 16;
   localparam logic [ADDR_W-1:0] TABLE_OFFSET = 16'h0400;
   localparam logic [3:0] CFG_SIZE_CODE = 4'h0;
   localparam int BLK_SHIFT = int'(CFG_SIZE_CODE) + 5;
   localparam int QW_W = BLK_SHIFT - 3;
   localparam logic [ADDR_W-1:0] TABLE_BYTES =
      ADDR_W'(NUM_WQ << BLK_SHIFT);
   localparam logic [7:0] QUEUE_COUNT = 8'h08;
   localparam logic [15:0] TOTAL_STORAGE = 16'h0080;
   // Dwords held per queue block; the rest read as zero
   localparam int NUM_DW = 5;
   localparam int DW_SIZE = 0;
   localparam int DW_THR = 1;
   localparam int DW_MODE = 2;
   localparam int DW_OCC = 3;
   localparam int DW_XFER = 4;
   // Field positions and writable masks
   localparam int SIZE_W = 16;
   localparam int MODE_BIT = 31;
   localparam int PASID_EN_BIT = 28;
   localparam int PRIO_LSB = 4;
   localparam int PRIO_W = 4;
   localparam logic [31:0] MASK_SIZE = 32'h0000FFFF;
   localparam logic [31:0] MASK_THR = 32'h0000FFFF;
   localparam logic [31:0] MASK_MODE_R10 = 32'hBFFFFF00;
   localparam logic [31:0] MASK_MODE_R11 = 32'h000000F8;
   localparam logic [31:0] MASK_OCC_IE = 32'h00000001;
   localparam logic [31:0] MASK_OCC_R10 = 32'hFFFF0000;
   localparam logic [31:0] MASK_XFER_R11 = 32'h000007FF;
   localparam logic [31:0] CFG_RESET = 32'h00000000;
   // Traffic class fields of the group configuration
   localparam int TC_W = 3;
   localparam int TC_FIRST_LSB = 0;
   localparam int TC_SECOND_LSB = 3;
   // Enable check results
   typedef enum logic [2:0] {
      ERR_NONE,
      ERR_DEV_OFF,
      ERR_INACTIVE,
      ERR_OVERSUB,
      ERR_PRIORITY,
      ERR_MODE
   } wqct_enerr_t;
   typedef enum logic {EN_IDLE, EN_CHECK} wqct_en_state_t;
endpackage : wqct_pkg

// ==== wqct_admit_if.sv ====
/*
 * Carrier between the table and its submission admit logic.
 * Assumes both ends share the table clock; the path is combinational.
 */
interface wqct_admit_if;
   logic [15:0] size;
   logic [15:0] threshold;
   logic dedicated;
   logic enabled;
   logic limited;
   logic [15:0] occupancy;
   logic [15:0] eff_threshold;
   logic accept;
   logic retry;
   modport table_end (output size, threshold, dedicated, enabled, limited,
      occupancy, input eff_threshold, accept, retry);
   modport admit_end (input size, threshold, dedicated, enabled, limited,
      occupancy, output eff_threshold, accept, retry);
endinterface : wqct_admit_if

// ==== wqct_admit.sv ====
/*
 * Admit decision for one work submission against its queue settings.
 * Assumes the caller presents the addressed queue's fields and occupancy.
 */
module wqct_admit (
   // Queue settings and submission
   wqct_admit_if.admit_end adm
);
   logic thr_clamped;

   // Threshold above the size behaves as the size
   assign thr_clamped = adm.threshold > adm.size;
   assign adm.eff_threshold = thr_clamped ? adm.size : adm.threshold;

   always_comb begin
      adm.accept = 1'b0;
      adm.retry = 1'b0;
      // Inactive or disabled queues take nothing
      if (adm.enabled && adm.size != 16'h0000) begin
         // Dedicated queues ignore the threshold
         if (!adm.dedicated && adm.limited &&
               adm.occupancy >= adm.eff_threshold) begin
            adm.retry = 1'b1;
         end else begin
            adm.accept = 1'b1;
         end
      end
   end
endmodule : wqct_admit

// ==== wqct_table.sv ====
/*
 * Work queue configuration table: per-queue register blocks, field locks,
 * enable checks, submission admit and traffic class selection.
 * Assumes all inputs come from logic on clk_i and that software keeps
 * its own programming order.
 */
module wqct_table (
   // Clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // Register access
   input wire logic reg_req_i,
   input wire logic reg_we_i,
   input wire logic [wqct_pkg::ADDR_W-1:0] reg_addr_i,
   input wire logic [1:0] reg_size_i,
   input wire logic [63:0] reg_wdata_i,
   output logic reg_ack_o,
   output logic reg_err_o,
   output logic [63:0] reg_rdata_o,
   // Capability and device state
   input wire logic cfg_support_i,
   input wire logic mode_support_i,
   input wire logic dev_enabled_i,
   output logic [7:0] queue_count_o,
   output logic [3:0] block_size_code_o,
   output logic [15:0] total_queue_storage_o,
   // Queue enable and disable commands
   input wire logic wq_enable_i,
   input wire logic wq_disable_i,
   input wire logic [wqct_pkg::IDX_W-1:0] wq_cmd_idx_i,
   output logic wq_cmd_done_o,
   output wqct_pkg::wqct_enerr_t wq_cmd_err_o,
   output logic [wqct_pkg::NUM_WQ-1:0] wq_enabled_o,
   // Work submission
   input wire logic sub_valid_i,
   input wire logic sub_limited_i,
   input wire logic [wqct_pkg::IDX_W-1:0] sub_wq_i,
   input wire logic [15:0] sub_occupancy_i,
   output logic sub_done_o,
   output logic sub_accept_o,
   output logic sub_retry_o,
   // Memory access traffic class
   input wire logic mem_req_i,
   input wire logic mem_tc_sel_i,
   input wire logic [5:0] group_tc_i,
   output logic mem_tc_valid_o,
   output logic [wqct_pkg::TC_W-1:0] mem_tc_o
);
   logic [31:0] cfg_r [wqct_pkg::NUM_WQ][wqct_pkg::NUM_DW];
   logic [wqct_pkg::NUM_WQ-1:0] wq_en_r;
   wqct_pkg::wqct_en_state_t en_state_r;
   logic [wqct_pkg::IDX_W-1:0] en_idx_r;
   logic [18:0] size_sum_r;
   logic cmd_done_r;
   wqct_pkg::wqct_enerr_t cmd_err_r;
   logic reg_ack_r;
   logic reg_err_r;
   logic [63:0] reg_rdata_r;
   logic sub_done_r;
   logic sub_accept_r;
   logic sub_retry_r;
   logic mem_tc_valid_r;
   logic [wqct_pkg::TC_W-1:0] mem_tc_r;

   logic [wqct_pkg::ADDR_W-1:0] rel_addr;
   logic in_table;
   logic misaligned;
   logic acc_ok;
   logic wr_ok;
   logic [wqct_pkg::IDX_W-1:0] acc_idx;
   logic [wqct_pkg::QW_W-1:0] acc_qw;
   logic [7:0] acc_be;
   logic [63:0] acc_bits;
   logic [63:0] rd_qword;
   logic [18:0] size_sum_nxt;
   wqct_pkg::wqct_enerr_t check_nxt;

   // Low address bits that must be zero for each access size
   function automatic logic [2:0] align_bits(input logic [1:0] sz);
      unique case (sz)
         2'h0: align_bits = 3'h0;
         2'h1: align_bits = 3'h1;
         2'h2: align_bits = 3'h3;
         2'h3: align_bits = 3'h7;
      endcase
   endfunction : align_bits

   // Byte lanes touched by an aligned access
   function automatic logic [7:0] lane_mask(input logic [1:0] sz,
         input logic [2:0] lo);
      logic [7:0] base;
      unique case (sz)
         2'h0: base = 8'h01;
         2'h1: base = 8'h03;
         2'h2: base = 8'h0F;
         2'h3: base = 8'hFF;
      endcase
      lane_mask = base << lo;
   endfunction : lane_mask

   function automatic logic [63:0] bit_mask(input logic [7:0] be);
      logic [63:0] m;
      m = 64'h0;
      for (int b = 0; b < 8; b++) begin
         m[8*b +: 8] = {8{be[b]}};
      end
      bit_mask = m;
   endfunction : bit_mask

   // Writable bits of one stored dword under the current states
   function automatic logic [31:0] wr_mask(input int dw, input logic cfg,
         input logic msup, input logic dev_en, input logic q_en);
      logic any_sup;
      logic [31:0] m;
      any_sup = cfg | msup;
      m = 32'h0;
      unique case (dw)
         wqct_pkg::DW_SIZE: begin
            if (cfg && !dev_en) begin
               m = wqct_pkg::MASK_SIZE;
            end
         end
         wqct_pkg::DW_THR: begin
            if (any_sup) begin
               m = wqct_pkg::MASK_THR;
            end
         end
         wqct_pkg::DW_MODE: begin
            if (any_sup && !q_en) begin
               m = wqct_pkg::MASK_MODE_R10;
            end
            if (cfg && !q_en) begin
               m = m | wqct_pkg::MASK_MODE_R11;
            end
         end
         wqct_pkg::DW_OCC: begin
            if (any_sup) begin
               m = wqct_pkg::MASK_OCC_IE;
            end
            if (any_sup && !q_en) begin
               m = m | wqct_pkg::MASK_OCC_R10;
            end
         end
         wqct_pkg::DW_XFER: begin
            if (cfg && !q_en) begin
               m = wqct_pkg::MASK_XFER_R11;
            end
         end
         default: m = 32'h0;
      endcase
      wr_mask = m;
   endfunction : wr_mask

   // Address decode: block index from base offset and block size
   assign rel_addr = reg_addr_i - wqct_pkg::TABLE_OFFSET;
   assign in_table = (reg_addr_i >= wqct_pkg::TABLE_OFFSET) &&
      (rel_addr < wqct_pkg::TABLE_BYTES);
   assign acc_idx = rel_addr[wqct_pkg::BLK_SHIFT +: wqct_pkg::IDX_W];
   assign acc_qw = rel_addr[3 +: wqct_pkg::QW_W];
   assign misaligned = (reg_addr_i[2:0] & align_bits(reg_size_i)) != 3'h0;
   assign acc_ok = reg_req_i && in_table && !misaligned;
   assign wr_ok = acc_ok && reg_we_i;
   assign acc_be = lane_mask(reg_size_i, reg_addr_i[2:0]);
   assign acc_bits = bit_mask(acc_be);

   // Qword read view; unheld dwords read as zero
   always_comb begin
      rd_qword = 64'h0;
      for (int h = 0; h < 2; h++) begin
         for (int d = 0; d < wqct_pkg::NUM_DW; d++) begin
            if (d == 2 * int'(acc_qw) + h) begin
               rd_qword[32*h +: 32] = cfg_r[acc_idx][d];
            end
         end
      end
   end

   // Field storage; locked bits keep their value
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         for (int q = 0; q < wqct_pkg::NUM_WQ; q++) begin
            for (int d = 0; d < wqct_pkg::NUM_DW; d++) begin
               cfg_r[q][d] <= wqct_pkg::CFG_RESET;
            end
         end
      end else if (wr_ok) begin
         for (int d = 0; d < wqct_pkg::NUM_DW; d++) begin
            if ((d >> 1) == int'(acc_qw)) begin
               cfg_r[acc_idx][d] <=
                  (cfg_r[acc_idx][d] &
                     ~(acc_bits[32*(d%2) +: 32] &
                       wr_mask(d, cfg_support_i, mode_support_i,
                          dev_enabled_i, wq_en_r[acc_idx]))) |
                  (reg_wdata_i[32*(d%2) +: 32] &
                     acc_bits[32*(d%2) +: 32] &
                     wr_mask(d, cfg_support_i, mode_support_i,
                        dev_enabled_i, wq_en_r[acc_idx]));
            end
         end
      end
   end

   // Register answer one cycle after the request
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         reg_ack_r <= 1'b0;
         reg_err_r <= 1'b0;
         reg_rdata_r <= 64'h0;
      end else begin
         reg_ack_r <= reg_req_i;
         // Misaligned or outside the table: refused, nothing changes
         reg_err_r <= reg_req_i && !acc_ok;
         if (acc_ok && !reg_we_i) begin
            reg_rdata_r <= rd_qword & acc_bits;
         end else begin
            reg_rdata_r <= 64'h0;
         end
      end
   end

   // Total storage claimed by all queues
   always_comb begin
      size_sum_nxt = 19'h0;
      for (int q = 0; q < wqct_pkg::NUM_WQ; q++) begin
         size_sum_nxt = size_sum_nxt +
            19'(cfg_r[q][wqct_pkg::DW_SIZE][wqct_pkg::SIZE_W-1:0]);
      end
   end

   // Consistency checks made at enable time
   always_comb begin
      check_nxt = wqct_pkg::ERR_NONE;
      if (!dev_enabled_i) begin
         check_nxt = wqct_pkg::ERR_DEV_OFF;
      end else if (cfg_r[en_idx_r][wqct_pkg::DW_SIZE][15:0] == 16'h0000) begin
         check_nxt = wqct_pkg::ERR_INACTIVE;
      end else if (size_sum_r > 19'(wqct_pkg::TOTAL_STORAGE)) begin
         check_nxt = wqct_pkg::ERR_OVERSUB;
      end else if (cfg_support_i && cfg_r[en_idx_r][wqct_pkg::DW_MODE]
            [wqct_pkg::PRIO_LSB +: wqct_pkg::PRIO_W] == 4'h0) begin
         check_nxt = wqct_pkg::ERR_PRIORITY;
      end else if (!cfg_r[en_idx_r][wqct_pkg::DW_MODE][wqct_pkg::MODE_BIT] &&
            !cfg_r[en_idx_r][wqct_pkg::DW_MODE][wqct_pkg::PASID_EN_BIT]) begin
         check_nxt = wqct_pkg::ERR_MODE;
      end
   end

   // Enable sequencer; the sum is registered first to keep the adder
   // chain out of the check path
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         en_state_r <= wqct_pkg::EN_IDLE;
         en_idx_r <= '0;
         size_sum_r <= 19'h0;
         wq_en_r <= '0;
         cmd_done_r <= 1'b0;
         cmd_err_r <= wqct_pkg::ERR_NONE;
      end else begin
         cmd_done_r <= 1'b0;
         unique case (en_state_r)
            wqct_pkg::EN_IDLE: begin
               if (wq_disable_i) begin
                  wq_en_r[wq_cmd_idx_i] <= 1'b0;
                  cmd_done_r <= 1'b1;
                  cmd_err_r <= wqct_pkg::ERR_NONE;
               end else if (wq_enable_i) begin
                  en_idx_r <= wq_cmd_idx_i;
                  size_sum_r <= size_sum_nxt;
                  en_state_r <= wqct_pkg::EN_CHECK;
               end
            end
            wqct_pkg::EN_CHECK: begin
               en_state_r <= wqct_pkg::EN_IDLE;
               cmd_done_r <= 1'b1;
               cmd_err_r <= check_nxt;
               if (check_nxt == wqct_pkg::ERR_NONE) begin
                  wq_en_r[en_idx_r] <= 1'b1;
               end
            end
         endcase
         // A disabled device holds every queue disabled
         if (!dev_enabled_i) begin
            wq_en_r <= '0;
         end
      end
   end

   // Submission admit for the addressed queue
   wqct_admit_if adm_if ();

   assign adm_if.size = cfg_r[sub_wq_i][wqct_pkg::DW_SIZE][15:0];
   assign adm_if.threshold = cfg_r[sub_wq_i][wqct_pkg::DW_THR][15:0];
   assign adm_if.dedicated =
      cfg_r[sub_wq_i][wqct_pkg::DW_MODE][wqct_pkg::MODE_BIT];
   assign adm_if.enabled = wq_en_r[sub_wq_i];
   assign adm_if.limited = sub_limited_i;
   assign adm_if.occupancy = sub_occupancy_i;

   wqct_admit u_admit (
      .adm (adm_if.admit_end)
   );

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         sub_done_r <= 1'b0;
         sub_accept_r <= 1'b0;
         sub_retry_r <= 1'b0;
      end else begin
         sub_done_r <= sub_valid_i;
         sub_accept_r <= sub_valid_i && adm_if.accept;
         sub_retry_r <= sub_valid_i && adm_if.retry;
      end
   end

   // Traffic class per descriptor selector
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         mem_tc_valid_r <= 1'b0;
         mem_tc_r <= '0;
      end else begin
         mem_tc_valid_r <= mem_req_i;
         if (mem_tc_sel_i) begin
            mem_tc_r <= group_tc_i[wqct_pkg::TC_SECOND_LSB +:
               wqct_pkg::TC_W];
         end else begin
            mem_tc_r <= group_tc_i[wqct_pkg::TC_FIRST_LSB +:
               wqct_pkg::TC_W];
         end
      end
   end

   // Capability report
   assign queue_count_o = wqct_pkg::QUEUE_COUNT;
   assign block_size_code_o = wqct_pkg::CFG_SIZE_CODE;
   assign total_queue_storage_o = wqct_pkg::TOTAL_STORAGE;

   assign reg_ack_o = reg_ack_r;
   assign reg_err_o = reg_err_r;
   assign reg_rdata_o = reg_rdata_r;
   assign wq_cmd_done_o = cmd_done_r;
   assign wq_cmd_err_o = cmd_err_r;
   assign wq_enabled_o = wq_en_r;
   assign sub_done_o = sub_done_r;
   assign sub_accept_o = sub_accept_r;
   assign sub_retry_o = sub_retry_r;
   assign mem_tc_valid_o = mem_tc_valid_r;
   assign mem_tc_o = mem_tc_r;
endmodule : wqct_table

// ==== wqct_table_assertions.sv ====
/*
 * Port-level checker of the work queue configuration table.
 * Assumes it is bound to wqct_table and sees only that module's ports.
 */
module wqct_table_assertions (
   // Clock, reset and register access
   input logic clk_i,
   input logic srst_i,
   input logic reg_req_i,
   input logic reg_we_i,
   input logic [wqct_pkg::ADDR_W-1:0] reg_addr_i,
   input logic [1:0] reg_size_i,
   input logic [63:0] reg_wdata_i,
   input logic reg_ack_o,
   input logic reg_err_o,
   input logic [63:0] reg_rdata_o,
   // Capability, device state and queue commands
   input logic cfg_support_i,
   input logic mode_support_i,
   input logic dev_enabled_i,
   input logic [7:0] queue_count_o,
   input logic [3:0] block_size_code_o,
   input logic [15:0] total_queue_storage_o,
   input logic wq_enable_i,
   input logic wq_disable_i,
   input logic [wqct_pkg::IDX_W-1:0] wq_cmd_idx_i,
   input logic wq_cmd_done_o,
   input wqct_pkg::wqct_enerr_t wq_cmd_err_o,
   input logic [wqct_pkg::NUM_WQ-1:0] wq_enabled_o,
   // Submission and traffic class
   input logic sub_valid_i,
   input logic sub_limited_i,
   input logic [wqct_pkg::IDX_W-1:0] sub_wq_i,
   input logic [15:0] sub_occupancy_i,
   input logic sub_done_o,
   input logic sub_accept_o,
   input logic sub_retry_o,
   input logic mem_req_i,
   input logic mem_tc_sel_i,
   input logic [5:0] group_tc_i,
   input logic mem_tc_valid_o,
   input logic [wqct_pkg::TC_W-1:0] mem_tc_o
);
   logic mis;
   logic outside;
   logic [2:0] tc_hi_r;
   logic [2:0] tc_lo_r;
   assign mis = (reg_addr_i[2:0] & ((3'h1 << reg_size_i) - 3'h1)) != 3'h0;
   assign outside = reg_addr_i < 16'h0400 || reg_addr_i > 16'h04FF;
   // Group fields kept one cycle, as the class comes out registered
   always_ff @(posedge clk_i) begin
      tc_hi_r <= group_tc_i[5:3];
      tc_lo_r <= group_tc_i[2:0];
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (srst_i);
   sequence s_reg_take; reg_req_i; endsequence
   sequence s_reg_answer; reg_ack_o; endsequence
   // An enable one cycle after another falls in a check cycle
   sequence s_en_take;
      wq_enable_i && !wq_disable_i && !$past(wq_enable_i);
   endsequence
   sequence s_en_answer; !wq_cmd_done_o ##1 wq_cmd_done_o; endsequence
   chk_reg_answer: assert property (s_reg_take |=> s_reg_answer)
      else $error("register request not answered");
   chk_misalign_err: assert property (reg_req_i && mis |=>
      reg_err_o && reg_rdata_o == 64'h0) else $error("misaligned taken");
   chk_outside_err: assert property (reg_req_i && outside |=>
      reg_err_o) else $error("access outside table not refused");
   chk_aligned_ok: assert property (reg_req_i && !mis && !outside |=>
      !reg_err_o) else $error("aligned access refused");
   chk_tc_second: assert property (mem_req_i && mem_tc_sel_i |=>
      mem_tc_valid_o && mem_tc_o == tc_hi_r) else $error("tc sel 1 wrong");
   chk_tc_first: assert property (mem_req_i && !mem_tc_sel_i |=>
      mem_tc_valid_o && mem_tc_o == tc_lo_r) else $error("tc sel 0 wrong");
   chk_sub_answer: assert property (sub_valid_i |=> sub_done_o &&
      !(sub_accept_o && sub_retry_o)) else $error("bad submit answer");
   chk_sub_refused: assert property (sub_valid_i &&
      !wq_enabled_o[sub_wq_i] |=> !sub_accept_o && !sub_retry_o)
      else $error("disabled queue took a submission");
   chk_en_answer: assert property (s_en_take |=> s_en_answer)
      else $error("enable check not done in two cycles");
   chk_en_result: assert property (wq_cmd_done_o && dev_enabled_i &&
      wq_cmd_err_o == wqct_pkg::ERR_NONE && $past(wq_enable_i, 2) |->
      wq_enabled_o[$past(wq_cmd_idx_i, 2)]) else $error("queue not enabled");
   chk_refused_hold: assert property (wq_cmd_done_o &&
      wq_cmd_err_o != wqct_pkg::ERR_NONE && $past(wq_enable_i, 2) &&
      dev_enabled_i && $past(dev_enabled_i) |-> $stable(wq_enabled_o))
      else $error("refused enable changed queue state");
   chk_caps_const: assert property (queue_count_o == 8'h08 &&
      block_size_code_o == 4'h0 && total_queue_storage_o == 16'h0080)
      else $error("capability outputs wrong");
endmodule : wqct_table_assertions

bind wqct_table wqct_table_assertions u_chk (.clk_i, .srst_i, .reg_req_i,
   .reg_we_i, .reg_addr_i, .reg_size_i, .reg_wdata_i, .reg_ack_o,
   .reg_err_o, .reg_rdata_o, .cfg_support_i, .mode_support_i,
   .dev_enabled_i, .queue_count_o, .block_size_code_o,
   .total_queue_storage_o, .wq_enable_i, .wq_disable_i, .wq_cmd_idx_i,
   .wq_cmd_done_o, .wq_cmd_err_o, .wq_enabled_o, .sub_valid_i,
   .sub_limited_i, .sub_wq_i, .sub_occupancy_i, .sub_done_o, .sub_accept_o,
   .sub_retry_o, .mem_req_i, .mem_tc_sel_i, .group_tc_i, .mem_tc_valid_o,
   .mem_tc_o);

// ==== tb_top.sv ====
/*
 * Self-checking bench of the work queue configuration table.
 * Assumes the checker file is compiled alongside and binds itself.
 */
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i, srst_i, reg_req_i, reg_we_i, reg_ack_o, reg_err_o;
   logic [wqct_pkg::ADDR_W-1:0] reg_addr_i;
   logic [1:0] reg_size_i;
   logic [63:0] reg_wdata_i, reg_rdata_o;
   logic cfg_support_i, mode_support_i, dev_enabled_i;
   logic [7:0] queue_count_o;
   logic [3:0] block_size_code_o;
   logic [15:0] total_queue_storage_o, sub_occupancy_i;
   logic wq_enable_i, wq_disable_i, wq_cmd_done_o;
   logic [2:0] wq_cmd_idx_i, sub_wq_i, mem_tc_o;
   wqct_pkg::wqct_enerr_t wq_cmd_err_o;
   logic [7:0] wq_enabled_o;
   logic sub_valid_i, sub_limited_i, sub_done_o, sub_accept_o, sub_retry_o;
   logic mem_req_i, mem_tc_sel_i, mem_tc_valid_o;
   logic [5:0] group_tc_i;
   int n_errors = 0;
   int total_checks = 0;
   wqct_table dut (.clk_i, .srst_i, .reg_req_i, .reg_we_i, .reg_addr_i,
      .reg_size_i, .reg_wdata_i, .reg_ack_o, .reg_err_o, .reg_rdata_o,
      .cfg_support_i, .mode_support_i, .dev_enabled_i, .queue_count_o,
      .block_size_code_o, .total_queue_storage_o, .wq_enable_i,
      .wq_disable_i, .wq_cmd_idx_i, .wq_cmd_done_o, .wq_cmd_err_o,
      .wq_enabled_o, .sub_valid_i, .sub_limited_i, .sub_wq_i,
      .sub_occupancy_i, .sub_done_o, .sub_accept_o, .sub_retry_o,
      .mem_req_i, .mem_tc_sel_i, .group_tc_i, .mem_tc_valid_o, .mem_tc_o);
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : report_and_stop
   // One-cycle request; the answer is sampled at the next falling edge
   task automatic acc(input logic we, input logic [15:0] a,
         input logic [1:0] s, input logic [63:0] d, input logic ee,
         input logic [63:0] er);
      @(negedge clk_i);
      reg_req_i = 1'b1;
      reg_we_i = we;
      reg_addr_i = a;
      reg_size_i = s;
      reg_wdata_i = d;
      @(negedge clk_i);
      reg_req_i = 1'b0;
      chk({62'h0, reg_ack_o, reg_err_o}, {62'h0, 1'b1, ee});
      chk(reg_rdata_o, er);
   endtask : acc
   task automatic wr32(input logic [15:0] a, input logic [31:0] d);
      acc(1'b1, a, 2'h2, {d, d}, 1'b0, 64'h0);
   endtask : wr32
   task automatic rd32(input logic [15:0] a, input logic [31:0] e);
      acc(1'b0, a, 2'h2, 64'h0, 1'b0, a[2] ? {e, 32'h0} : {32'h0, e});
   endtask : rd32
   task automatic caps(input logic c, input logic m, input logic d);
      @(negedge clk_i);
      cfg_support_i = c;
      mode_support_i = m;
      dev_enabled_i = d;
   endtask : caps
   // Result code is judged only for enables; disable leaves it open
   task automatic cmd(input logic en, input logic [2:0] q,
         input wqct_pkg::wqct_enerr_t ee);
      int n;
      @(negedge clk_i);
      wq_enable_i = en;
      wq_disable_i = !en;
      wq_cmd_idx_i = q;
      @(negedge clk_i);
      wq_enable_i = 1'b0;
      wq_disable_i = 1'b0;
      n = 0;
      while (wq_cmd_done_o !== 1'b1 && n < 4) begin
         @(negedge clk_i);
         n++;
      end
      chk({63'h0, wq_cmd_done_o}, 64'h1);
      if (en) chk({61'h0, wq_cmd_err_o}, {61'h0, ee});
   endtask : cmd
   task automatic sub(input logic [2:0] q, input logic lim,
         input logic [15:0] occ, input logic ea, input logic er);
      @(negedge clk_i);
      sub_valid_i = 1'b1;
      sub_wq_i = q;
      sub_limited_i = lim;
      sub_occupancy_i = occ;
      @(negedge clk_i);
      sub_valid_i = 1'b0;
      chk({61'h0, sub_done_o, sub_accept_o, sub_retry_o},
         {61'h0, 1'b1, ea, er});
   endtask : sub
   task automatic t_caps_align;
      chk({36'h0, queue_count_o, block_size_code_o, total_queue_storage_o},
         {36'h0, 8'h08, 4'h0, 16'h0080});
      acc(1'b0, 16'h0400, 2'h3, 64'h0, 1'b0, 64'h0);
      for (int s = 1; s < 4; s++) begin
         acc(1'b0, 16'h0401, 2'(s), 64'h0, 1'b1, 64'h0);
      end
      acc(1'b1, 16'h0464, 2'h3, 64'h1, 1'b1, 64'h0);
      acc(1'b0, 16'h0500, 2'h2, 64'h0, 1'b1, 64'h0);
      acc(1'b0, 16'h03FC, 2'h2, 64'h0, 1'b1, 64'h0);
      acc(1'b0, 16'h0403, 2'h0, 64'h0, 1'b0, 64'h0);
      $display("caps and alignment test done");
   endtask : t_caps_align
   task automatic t_size_lock;
      caps(1'b1, 1'b1, 1'b0);
      wr32(16'h0460, 32'hFFFF_0010);
      rd32(16'h0460, 32'h10);
      caps(1'b1, 1'b1, 1'b1);
      wr32(16'h0460, 32'h20);
      rd32(16'h0460, 32'h10);
      caps(1'b0, 1'b1, 1'b0);
      wr32(16'h0460, 32'h20);
      rd32(16'h0460, 32'h10);
      acc(1'b0, 16'h0460, 2'h3, 64'h0, 1'b0, 64'h10);
      $display("size lock test done");
   endtask : t_size_lock
   task automatic t_thr_lock;
      caps(1'b0, 1'b0, 1'b0);
      wr32(16'h0464, 32'h4);
      rd32(16'h0464, 32'h0);
      wr32(16'h046C, 32'h1);
      rd32(16'h046C, 32'h0);
      caps(1'b0, 1'b1, 1'b1);
      wr32(16'h0464, 32'hFFFF_0004);
      rd32(16'h0464, 32'h4);
      wr32(16'h046C, 32'h1);
      rd32(16'h046C, 32'h1);
      wr32(16'h046C, 32'h0);
      $display("threshold lock test done");
   endtask : t_thr_lock
   // Sizes are set with the device off; the sum first overshoots storage
   task automatic t_enable;
      caps(1'b1, 1'b1, 1'b0);
      wr32(16'h0420, 32'h78);
      wr32(16'h0468, 32'h9000_0010);
      rd32(16'h0468, 32'h9000_0010);
      cmd(1'b1, 3'h3, wqct_pkg::ERR_DEV_OFF);
      caps(1'b1, 1'b1, 1'b1);
      cmd(1'b1, 3'h3, wqct_pkg::ERR_OVERSUB);
      caps(1'b1, 1'b1, 1'b0);
      wr32(16'h0420, 32'h70);
      caps(1'b1, 1'b1, 1'b1);
      cmd(1'b1, 3'h0, wqct_pkg::ERR_INACTIVE);
      cmd(1'b1, 3'h1, wqct_pkg::ERR_PRIORITY);
      wr32(16'h0428, 32'h10);
      cmd(1'b1, 3'h1, wqct_pkg::ERR_MODE);
      wr32(16'h0428, 32'h1000_0010);
      cmd(1'b1, 3'h1, wqct_pkg::ERR_NONE);
      cmd(1'b1, 3'h3, wqct_pkg::ERR_NONE);
      chk({56'h0, wq_enabled_o}, 64'h0A);
      wr32(16'h0468, 32'h0);
      rd32(16'h0468, 32'h9000_0010);
      cmd(1'b0, 3'h3, wqct_pkg::ERR_NONE);
      caps(1'b0, 1'b1, 1'b1);
      wr32(16'h0468, 32'h1000_00F0);
      rd32(16'h0468, 32'h1000_0010);
      caps(1'b1, 1'b1, 1'b1);
      wr32(16'h0468, 32'h9000_0010);
      cmd(1'b1, 3'h3, wqct_pkg::ERR_NONE);
      $display("enable and field lock test done");
   endtask : t_enable
   task automatic t_submit;
      wr32(16'h0424, 32'h4);
      sub(3'h1, 1'b1, 16'h3, 1'b1, 1'b0);
      sub(3'h1, 1'b1, 16'h4, 1'b0, 1'b1);
      sub(3'h1, 1'b0, 16'h4, 1'b1, 1'b0);
      wr32(16'h0424, 32'hFFFF);
      sub(3'h1, 1'b1, 16'h70, 1'b0, 1'b1);
      sub(3'h1, 1'b1, 16'h6F, 1'b1, 1'b0);
      wr32(16'h0464, 32'h2);
      sub(3'h3, 1'b1, 16'h5, 1'b1, 1'b0);
      sub(3'h0, 1'b1, 16'h0, 1'b0, 1'b0);
      $display("submission test done");
   endtask : t_submit
   task automatic t_tc;
      for (int i = 0; i < 4; i++) begin
         @(negedge clk_i);
         mem_req_i = 1'b1;
         mem_tc_sel_i = i[0];
         group_tc_i = i[1] ? 6'h15 : 6'h2A;
         @(negedge clk_i);
         mem_req_i = 1'b0;
         chk({60'h0, mem_tc_valid_o, mem_tc_o}, {60'h0, 1'b1,
            i[0] ? group_tc_i[5:3] : group_tc_i[2:0]});
      end
      $display("traffic class test done");
   endtask : t_tc
   // Whole run is under 150 cycles; 3000 is twenty times that and means a hang
   initial begin
      repeat (3000) @(posedge clk_i);
      n_errors++;
      report_and_stop();
   end
   initial begin
      srst_i = 1'b1;
      {reg_req_i, reg_we_i, reg_size_i, reg_addr_i, reg_wdata_i} = '0;
      {cfg_support_i, mode_support_i, dev_enabled_i} = 3'b110;
      {wq_enable_i, wq_disable_i, wq_cmd_idx_i} = '0;
      {sub_valid_i, sub_limited_i, sub_wq_i, sub_occupancy_i} = '0;
      {mem_req_i, mem_tc_sel_i, group_tc_i} = '0;
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
      srst_i = 1'b0;
      t_caps_align();
      t_size_lock();
      t_thr_lock();
      t_enable();
      t_submit();
      t_tc();
      report_and_stop();
   end
endmodule : tb_top
